// >>> clk_switch_defs.svh
// Register offsets, field positions and codes for the input switch block
`ifndef CLK_SWITCH_DEFS_SVH
`define CLK_SWITCH_DEFS_SVH

`define ADDR_HOLD_CNT_LO   16'h0532
`define ADDR_HOLD_CNT_MID  16'h0533
`define ADDR_HOLD_CNT_HI   16'h0534
`define ADDR_FORCE_HOLD    16'h0535
`define ADDR_SWITCH_CTRL   16'h0536
`define ADDR_FAULT_MASK    16'h0537
`define ADDR_PRIO_FIRST    16'h0538
`define ADDR_PRIO_SECOND   16'h0539
`define ADDR_HSW_MODE      16'h053a
`define ADDR_PH_THR_LO     16'h053b
`define ADDR_PH_THR_HI     16'h053c
`define ADDR_COARSE_LEN    16'h053d
`define ADDR_HIST_STATUS   16'h053f
`define ADDR_SEL_STATUS    16'h0541

// Writable bits of each register that does not take all eight bits
`define MASK_FORCE_HOLD    8'h01
`define MASK_SWITCH_CTRL   8'h07
`define MASK_PRIO          8'h77
`define MASK_HSW_MODE      8'h0f
`define MASK_PH_THR_HI     8'h03
`define MASK_COARSE_LEN    8'h1f

`define RST_ZERO           8'h00
`define RST_HSW_MODE       8'h01

`define BIT_FORCE_HOLD     0
`define BIT_HITLESS_EN     2
`define BIT_HIST_VALID     1
`define POLICY_HI          1
`define POLICY_LO          0
`define LOSS_MASK_HI       3
`define LOSS_MASK_LO       0
`define FREQ_MASK_HI       7
`define FREQ_MASK_LO       4
`define RANK_LO_HI         2
`define RANK_LO_LO         0
`define RANK_HI_HI         6
`define RANK_HI_LO         4

`define RANK_NONE          3'h0
`define RANK_LAST          3'h4

`endif

// >>> clk_switch_pkg.sv
// Types shared by the input switch block
package clk_switch_pkg;
    typedef enum logic [2:0] {
        ST_TRACK = 3'b001,
        ST_HOLD  = 3'b010,
        ST_FREE  = 3'b100
    } path_state_e;

    typedef enum logic [1:0] {
        POL_MANUAL  = 2'h0,
        POL_AUTO_NR = 2'h1,
        POL_AUTO_RV = 2'h2,
        POL_RSVD    = 2'h3
    } switch_policy_e;
endpackage : clk_switch_pkg

// >>> input_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module input_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] mid_reg;
    logic [WIDTH-1:0] late_reg;
    logic [WIDTH-1:0] sync_next;
    logic [WIDTH-1:0] agree;

    if (WIDTH < 1) begin : g_chk
        $error("input_sync needs WIDTH of at least one");
    end

    assign agree     = ~(mid_reg ^ late_reg);
    assign sync_next = (agree & late_reg) | (~agree & sync_out);

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            mid_reg  <= '0;
            late_reg <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta_reg <= async_in;
            mid_reg  <= meta_reg;
            late_reg <= mid_reg;
            sync_out <= sync_next;
        end
    end
endmodule : input_sync
`default_nettype wire

// >>> rank_pick.sv
// Picks the eligible input with the best rank, lowest index on a tie
`timescale 1ns/10ps
`default_nettype none
`include "clk_switch_defs.svh"
module rank_pick #(
    parameter int NUM_IN = 4
) (
    input  wire logic [3*NUM_IN-1:0]     ranks,
    input  wire logic [NUM_IN-1:0]       usable,
    output var  logic                    found,
    output var  logic [$clog2(NUM_IN)-1:0] idx,
    output var  logic [2:0]              best
);
    if (NUM_IN < 2) begin : g_chk
        $error("rank_pick needs at least two inputs");
    end

    // Rank zero and reserved codes never take part in automatic choice
    function automatic logic rank_ok(input logic [2:0] r);
        rank_ok = (r != `RANK_NONE) && (r <= `RANK_LAST);
    endfunction : rank_ok

    always_comb begin
        found = 1'b0;
        idx   = '0;
        best  = `RANK_NONE;
        // Strict less-than keeps the lowest index among equal ranks
        for (int i = 0; i < NUM_IN; i++) begin
            if (usable[i] && rank_ok(ranks[3*i +: 3]) &&
                (!found || ranks[3*i +: 3] < best)) begin
                found = 1'b1;
                idx   = i[$clog2(NUM_IN)-1:0];
                best  = ranks[3*i +: 3];
            end
        end
    end
endmodule : rank_pick
`default_nettype wire

// >>> pll_input_switch_holdover_ctrl.sv
// Reference input selection, holdover/freerun control and config registers
//
// How it works
// - Force bit holds output, clearing resumes tracking
// - Forced: freerun without history, else holdover
// - Policy 0 manual, 1 non-revertive, 2 revertive
// - Hitless bit allows switching without holdover step
// - Loss mask bit set ignores that loss fault
// - Frequency mask bit set ignores frequency fault
// - Automatic picks valid input with best rank
// - Rank zero never auto-picked, manual still allowed
// - Equal ranks resolve to lowest input index
// - No usable selected input leaves tracking for holdover or freerun
// - Failure or non-hitless switch: holdover if history, else freerun
// - Manual uses pin unless register select is high
`timescale 1ns/10ps
`default_nettype none
`include "clk_switch_defs.svh"
module pll_input_switch_holdover_ctrl
    import clk_switch_pkg::*;
#(
    parameter int NUM_IN = 4
) (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        CLK_EN,
    input  wire logic [15:0] REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output var  logic [7:0]  REG_RDATA,
    input  wire logic [3:0]  SIGNAL_LOSS_FAULT,
    input  wire logic [3:0]  FREQUENCY_OFFSET_FAULT,
    input  wire logic [1:0]  SEL_PIN,
    input  wire logic        SELECT_FROM_REGISTER,
    input  wire logic [1:0]  REG_INPUT_SEL,
    input  wire logic        HISTORY_VALID,
    output var  logic [1:0]  SEL_INPUT,
    output var  logic        TRACKING,
    output var  logic        HOLDOVER,
    output var  logic        FREERUN,
    output var  logic        HITLESS_SWITCH
);
    if (NUM_IN != 4) begin : g_chk
        $error("Register layout serves exactly four inputs");
    end

    logic [7:0]  hold_cnt_lo_reg;
    logic [7:0]  hold_cnt_mid_reg;
    logic [7:0]  hold_cnt_hi_reg;
    logic [7:0]  force_reg;
    logic [7:0]  switch_ctrl_reg;
    logic [7:0]  fault_mask_reg;
    logic [7:0]  prio_first_reg;
    logic [7:0]  prio_second_reg;
    logic [7:0]  hsw_mode_reg;
    logic [7:0]  ph_thr_lo_reg;
    logic [7:0]  ph_thr_hi_reg;
    logic [7:0]  coarse_len_reg;
    logic [7:0]  rdata_next;
    path_state_e state_reg;
    path_state_e state_next;
    logic [1:0]  sel_reg;
    logic [1:0]  sel_next;
    logic        hsw_pulse_next;

    logic [3:0]  loss_sync;
    logic [3:0]  freq_sync;
    logic [1:0]  pin_sync;

    logic        force_holdover_b;
    logic        hitless_enable_b;
    switch_policy_e switch_policy_b;
    logic [3:0]  signal_loss_mask_b;
    logic [3:0]  freq_offset_mask_b;
    logic [11:0] ranks;
    logic [3:0]  input_ok;
    logic        best_found;
    logic [1:0]  best_idx;
    logic [2:0]  best_rank;
    logic [1:0]  manual_sel;
    logic        is_auto;
    logic        cur_keep;
    logic [1:0]  target;
    logic        target_ok;
    logic        is_switch;
    path_state_e lost_state;

    input_sync #(.WIDTH(4)) u_loss_sync (
        .clk      (CLK),
        .rst      (SYS_RST),
        .ce       (CLK_EN),
        .async_in (SIGNAL_LOSS_FAULT),
        .sync_out (loss_sync)
    );

    input_sync #(.WIDTH(4)) u_freq_sync (
        .clk      (CLK),
        .rst      (SYS_RST),
        .ce       (CLK_EN),
        .async_in (FREQUENCY_OFFSET_FAULT),
        .sync_out (freq_sync)
    );

    input_sync #(.WIDTH(2)) u_pin_sync (
        .clk      (CLK),
        .rst      (SYS_RST),
        .ce       (CLK_EN),
        .async_in (SEL_PIN),
        .sync_out (pin_sync)
    );

    assign force_holdover_b   = force_reg[`BIT_FORCE_HOLD];
    assign hitless_enable_b   = switch_ctrl_reg[`BIT_HITLESS_EN];
    assign switch_policy_b    =
        switch_policy_e'(switch_ctrl_reg[`POLICY_HI:`POLICY_LO]);
    assign signal_loss_mask_b = fault_mask_reg[`LOSS_MASK_HI:`LOSS_MASK_LO];
    assign freq_offset_mask_b = fault_mask_reg[`FREQ_MASK_HI:`FREQ_MASK_LO];
    assign ranks = {prio_second_reg[`RANK_HI_HI:`RANK_HI_LO],
                    prio_second_reg[`RANK_LO_HI:`RANK_LO_LO],
                    prio_first_reg[`RANK_HI_HI:`RANK_HI_LO],
                    prio_first_reg[`RANK_LO_HI:`RANK_LO_LO]};

    assign input_ok = ~(loss_sync & ~signal_loss_mask_b) &
                      ~(freq_sync & ~freq_offset_mask_b);

    rank_pick #(.NUM_IN(4)) u_pick (
        .ranks  (ranks),
        .usable (input_ok),
        .found  (best_found),
        .idx    (best_idx),
        .best   (best_rank)
    );

    assign manual_sel = SELECT_FROM_REGISTER ? REG_INPUT_SEL : pin_sync;
    // reserved policy code behaves as manual
    assign is_auto = (switch_policy_b == POL_AUTO_NR) ||
                     (switch_policy_b == POL_AUTO_RV);
    // Rank zero and reserved codes never count as ranked
    function automatic logic rank_ok(input logic [2:0] r);
        rank_ok = (r != `RANK_NONE) && (r <= `RANK_LAST);
    endfunction : rank_ok

    // non-revertive keeps a still-valid, still-ranked input
    assign cur_keep = (switch_policy_b == POL_AUTO_NR) &&
                      (state_reg == ST_TRACK) && input_ok[sel_reg] &&
                      rank_ok(ranks[3*sel_reg +: 3]);
    // auto result only from ranked inputs; manual ignores rank
    assign target = !is_auto ? manual_sel :
                    cur_keep ? sel_reg : best_idx;
    assign target_ok = is_auto ? (cur_keep || best_found) : input_ok[target];
    assign is_switch = (state_reg == ST_TRACK) && target_ok &&
                       (target != sel_reg);
    assign lost_state = HISTORY_VALID ? ST_HOLD : ST_FREE;

    always_comb begin
        state_next     = state_reg;
        sel_next       = sel_reg;
        hsw_pulse_next = 1'b0;
        if (force_holdover_b) begin
            state_next = lost_state;
        end else if (!target_ok) begin
            state_next = (state_reg == ST_TRACK) ? lost_state : state_reg;
        end else if (is_switch && !hitless_enable_b) begin
            // a plain switch passes through one lost cycle
            state_next = lost_state;
            sel_next   = target;
        end else begin
            state_next     = ST_TRACK;
            sel_next       = target;
            hsw_pulse_next = is_switch;
        end
    end

    always_comb begin
        case (REG_ADDR)
            `ADDR_HOLD_CNT_LO:  rdata_next = hold_cnt_lo_reg;
            `ADDR_HOLD_CNT_MID: rdata_next = hold_cnt_mid_reg;
            `ADDR_HOLD_CNT_HI:  rdata_next = hold_cnt_hi_reg;
            `ADDR_FORCE_HOLD:   rdata_next = force_reg;
            `ADDR_SWITCH_CTRL:  rdata_next = switch_ctrl_reg;
            `ADDR_FAULT_MASK:   rdata_next = fault_mask_reg;
            `ADDR_PRIO_FIRST:   rdata_next = prio_first_reg;
            `ADDR_PRIO_SECOND:  rdata_next = prio_second_reg;
            `ADDR_HSW_MODE:     rdata_next = hsw_mode_reg;
            `ADDR_PH_THR_LO:    rdata_next = ph_thr_lo_reg;
            `ADDR_PH_THR_HI:    rdata_next = ph_thr_hi_reg;
            `ADDR_COARSE_LEN:   rdata_next = coarse_len_reg;
            `ADDR_HIST_STATUS:
                rdata_next = {6'h00, HISTORY_VALID, 1'b0};
            `ADDR_SEL_STATUS:
                rdata_next = {3'h0, state_reg, sel_reg};
            default:            rdata_next = 8'h00;
        endcase
    end

    // Config writes; hitless mode keeps only bits 3:0 of the written value
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            hold_cnt_lo_reg  <= `RST_ZERO;
            hold_cnt_mid_reg <= `RST_ZERO;
            hold_cnt_hi_reg  <= `RST_ZERO;
            force_reg        <= `RST_ZERO;
            switch_ctrl_reg  <= `RST_ZERO;
            fault_mask_reg   <= `RST_ZERO;
            prio_first_reg   <= `RST_ZERO;
            prio_second_reg  <= `RST_ZERO;
            hsw_mode_reg     <= `RST_HSW_MODE;
            ph_thr_lo_reg    <= `RST_ZERO;
            ph_thr_hi_reg    <= `RST_ZERO;
            coarse_len_reg   <= `RST_ZERO;
        end else if (CLK_EN && REG_WR) begin
            case (REG_ADDR)
                `ADDR_HOLD_CNT_LO:  hold_cnt_lo_reg  <= REG_WDATA;
                `ADDR_HOLD_CNT_MID: hold_cnt_mid_reg <= REG_WDATA;
                `ADDR_HOLD_CNT_HI:  hold_cnt_hi_reg  <= REG_WDATA;
                `ADDR_FORCE_HOLD:
                    force_reg <= REG_WDATA & `MASK_FORCE_HOLD;
                `ADDR_SWITCH_CTRL:
                    switch_ctrl_reg <= REG_WDATA & `MASK_SWITCH_CTRL;
                `ADDR_FAULT_MASK:   fault_mask_reg <= REG_WDATA;
                // rank codes stored as written, reserved ones never win
                `ADDR_PRIO_FIRST:
                    prio_first_reg <= REG_WDATA & `MASK_PRIO;
                `ADDR_PRIO_SECOND:
                    prio_second_reg <= REG_WDATA & `MASK_PRIO;
                `ADDR_HSW_MODE:
                    hsw_mode_reg <= REG_WDATA & `MASK_HSW_MODE;
                `ADDR_PH_THR_LO:    ph_thr_lo_reg <= REG_WDATA;
                `ADDR_PH_THR_HI:
                    ph_thr_hi_reg <= REG_WDATA & `MASK_PH_THR_HI;
                `ADDR_COARSE_LEN:
                    coarse_len_reg <= REG_WDATA & `MASK_COARSE_LEN;
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_reg      <= ST_FREE;
            sel_reg        <= 2'h0;
            REG_RDATA      <= 8'h00;
            HITLESS_SWITCH <= 1'b0;
        end else if (CLK_EN) begin
            state_reg      <= state_next;
            sel_reg        <= sel_next;
            HITLESS_SWITCH <= hsw_pulse_next;
            if (REG_RD) begin
                REG_RDATA <= rdata_next;
            end
        end
    end

    assign SEL_INPUT = sel_reg;
    assign TRACKING  = state_reg[0];
    assign HOLDOVER  = state_reg[1];
    assign FREERUN   = state_reg[2];

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    force_enter_a: assert property (
        CLK_EN && force_holdover_b |=> !TRACKING)
        else $error("Forced holdover still tracking");
    force_branch_a: assert property (
        CLK_EN && force_holdover_b |=>
            (HOLDOVER == $past(HISTORY_VALID)) &&
            (FREERUN == !$past(HISTORY_VALID)))
        else $error("Forced mode ignores history");
    manual_follow_a: assert property (
        CLK_EN && !is_auto && !force_holdover_b && input_ok[manual_sel]
        |=> SEL_INPUT == $past(manual_sel))
        else $error("Manual selection not followed");
    hitless_gate_a: assert property (
        HITLESS_SWITCH && $past(CLK_EN) |->
            $past(hitless_enable_b) && TRACKING &&
            (SEL_INPUT != $past(SEL_INPUT)))
        else $error("Hitless pulse without enable or switch");
    auto_valid_a: assert property (
        TRACKING && $past(is_auto) && $past(CLK_EN) |->
            $past(input_ok[sel_next]))
        else $error("Automatic mode tracks a faulty input");
    auto_rank_a: assert property (
        TRACKING && $past(is_auto) && $past(CLK_EN) |->
            ($past(ranks[3*sel_next +: 3]) != `RANK_NONE))
        else $error("Rank zero input chosen automatically");
    revert_best_a: assert property (
        CLK_EN && switch_policy_b == POL_AUTO_RV && best_found &&
        !force_holdover_b |=> SEL_INPUT == $past(best_idx))
        else $error("Revertive mode misses best input");
    tie_low_a: assert property (
        best_found && input_ok[0] && ranks[2:0] == best_rank |->
            best_idx == 2'h0)
        else $error("Tie not resolved to lowest index");
    lost_exit_a: assert property (
        CLK_EN && TRACKING && !target_ok |=>
            (HOLDOVER == $past(HISTORY_VALID)) && !TRACKING)
        else $error("Loss of input not leaving tracking");
    keep_cur_a: assert property (
        CLK_EN && cur_keep && !force_holdover_b |=>
            SEL_INPUT == $past(SEL_INPUT) && TRACKING)
        else $error("Non-revertive mode left a good input");
endmodule : pll_input_switch_holdover_ctrl
`default_nettype wire

// >>> ref_fault_model.sv
// Four reference inputs with their loss and frequency fault detectors
`timescale 1ns/10ps
`default_nettype none
module ref_fault_model #(
    parameter int LAG = 1
) (
    input  wire logic       clk,
    input  wire logic [3:0] loss_req,
    input  wire logic [3:0] freq_req,
    output var  logic [3:0] loss_out,
    output var  logic [3:0] freq_out
);
    if (LAG < 1) begin : g_chk
        $error("ref_fault_model needs LAG of at least one");
    end

    logic [3:0] loss_pipe [LAG];
    logic [3:0] freq_pipe [LAG];

    // Detectors report a fault only after their own measurement lag
    always_ff @(posedge clk) begin
        loss_pipe[0] <= loss_req;
        freq_pipe[0] <= freq_req;
        for (int i = 1; i < LAG; i++) begin
            loss_pipe[i] <= loss_pipe[i-1];
            freq_pipe[i] <= freq_pipe[i-1];
        end
    end

    assign loss_out = loss_pipe[LAG-1];
    assign freq_out = freq_pipe[LAG-1];
endmodule : ref_fault_model
`default_nettype wire

// >>> testbench.sv
// Register and selection tests for the input switch block
`timescale 1ns/10ps
`default_nettype none
`include "clk_switch_defs.svh"
module testbench
    import clk_switch_pkg::*;
;

    logic        clk;
    logic        clk_en;
    logic        sys_rst;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [3:0]  loss_req;
    logic [3:0]  freq_req;
    logic [3:0]  loss_flt;
    logic [3:0]  freq_flt;
    logic [1:0]  sel_pin;
    logic        sel_from_reg;
    logic [1:0]  reg_input_sel;
    logic        history_valid;
    logic [1:0]  sel_input;
    logic        tracking;
    logic        holdover;
    logic        freerun;
    logic        hitless_switch;
    logic [2:0]  state_now;
    int          err_total;
    int          checks;
    int          hs_cnt;
    int          drop_cnt;
    logic [15:0] rst_addr [12];

    assign state_now = {freerun, holdover, tracking};

    pll_input_switch_holdover_ctrl dut (
        .CLK                    (clk),
        .SYS_RST                (sys_rst),
        .CLK_EN                 (clk_en),
        .REG_ADDR               (reg_addr),
        .REG_WDATA              (reg_wdata),
        .REG_WR                 (reg_wr),
        .REG_RD                 (reg_rd),
        .REG_RDATA              (reg_rdata),
        .SIGNAL_LOSS_FAULT      (loss_flt),
        .FREQUENCY_OFFSET_FAULT (freq_flt),
        .SEL_PIN                (sel_pin),
        .SELECT_FROM_REGISTER   (sel_from_reg),
        .REG_INPUT_SEL          (reg_input_sel),
        .HISTORY_VALID          (history_valid),
        .SEL_INPUT              (sel_input),
        .TRACKING               (tracking),
        .HOLDOVER               (holdover),
        .FREERUN                (freerun),
        .HITLESS_SWITCH         (hitless_switch)
    );

    ref_fault_model #(.LAG(2)) refs (
        .clk      (clk),
        .loss_req (loss_req),
        .freq_req (freq_req),
        .loss_out (loss_flt),
        .freq_out (freq_flt)
    );

    always #12.5 clk = ~clk;

    // Counts hitless pulses and any cycle spent off tracking
    always @(posedge clk) begin
        if (hitless_switch === 1'b1) hs_cnt++;
        if (tracking !== 1'b1) drop_cnt++;
    end

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input string nm, input logic [15:0] a,
                      input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk(nm, e, reg_rdata);
    endtask : rd

    // Bounded wait for a settled selection and path state
    task automatic wait_for(input string nm, input logic [1:0] s,
                            input logic [2:0] st, input bit use_sel);
        int n;
        n = 0;
        while (n < 40 && !(state_now === st &&
               (!use_sel || sel_input === s))) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({nm, " state"}, {5'h0, st}, {5'h0, state_now});
        if (use_sel) chk({nm, " sel"}, {6'h0, s}, {6'h0, sel_input});
    endtask : wait_for

    task automatic stop_test;
        $display("Comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        stop_test();
    end

    initial begin
        clk = 1'b0;
        clk_en = 1'b1;
        sys_rst = 1'b1;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        loss_req = 4'h0;
        freq_req = 4'h0;
        sel_pin = 2'h0;
        sel_from_reg = 1'b0;
        reg_input_sel = 2'h0;
        history_valid = 1'b1;
        err_total = 0;
        checks = 0;
        hs_cnt = 0;
        drop_cnt = 0;
        for (int i = 0; i < 12; i++)
            rst_addr[i] = `ADDR_HOLD_CNT_LO + 16'(i);
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;

        // Reset values: all zero except hitless mode which is 1
        for (int i = 0; i < 12; i++)
            rd("reset value", rst_addr[i],
               (rst_addr[i] == `ADDR_HSW_MODE) ? 8'h01 : 8'h00);
        wr(`ADDR_SWITCH_CTRL, 8'hff);
        rd("switch ctrl bits", `ADDR_SWITCH_CTRL, 8'h07);
        wr(16'h0540, 8'h5a);
        rd("unmapped", 16'h0540, 8'h00);
        rd("history bit", `ADDR_HIST_STATUS, 8'h02);
        $display("Test registers done");

        // Manual mode: pin unless register select, rank 0 still usable
        wr(`ADDR_SWITCH_CTRL, 8'h00);
        wr(`ADDR_PRIO_FIRST, 8'h20);
        wr(`ADDR_PRIO_SECOND, 8'h11);
        @(posedge clk) sel_pin <= 2'h3;
        wait_for("manual pin", 2'h3, ST_TRACK, 1'b1);
        @(posedge clk) sel_from_reg <= 1'b1;
        wait_for("manual reg", 2'h0, ST_TRACK, 1'b1);
        $display("Test manual done");

        // Automatic revertive: in0 rank 0 skipped, tie of in2/in3
        wr(`ADDR_SWITCH_CTRL, 8'h02);
        wait_for("auto best", 2'h2, ST_TRACK, 1'b1);
        @(posedge clk) loss_req <= 4'h4;
        wait_for("auto loss", 2'h3, ST_TRACK, 1'b1);
        wr(`ADDR_FAULT_MASK, 8'h04);
        wait_for("loss masked", 2'h2, ST_TRACK, 1'b1);
        wr(`ADDR_FAULT_MASK, 8'h00);
        wait_for("loss unmasked", 2'h3, ST_TRACK, 1'b1);
        $display("Test revertive done");

        // Non-revertive keeps in3 when in2 recovers
        wr(`ADDR_SWITCH_CTRL, 8'h01);
        @(posedge clk) loss_req <= 4'h0;
        repeat (10) @(posedge clk);
        #1;
        chk("non revertive sel", 8'h03, {6'h0, sel_input});
        @(posedge clk) freq_req <= 4'h8;
        wait_for("freq fault", 2'h2, ST_TRACK, 1'b1);
        wr(`ADDR_FAULT_MASK, 8'h80);
        @(posedge clk) freq_req <= 4'hc;
        wait_for("freq masked", 2'h3, ST_TRACK, 1'b1);
        @(posedge clk) freq_req <= 4'h0;
        repeat (8) @(posedge clk);
        wr(`ADDR_FAULT_MASK, 8'h00);
        $display("Test non revertive done");

        // Hitless switch stays tracking and pulses once
        wr(`ADDR_SWITCH_CTRL, 8'h05);
        repeat (10) @(posedge clk);
        hs_cnt = 0;
        drop_cnt = 0;
        @(posedge clk) loss_req <= 4'h8;
        wait_for("hitless", 2'h2, ST_TRACK, 1'b1);
        repeat (3) @(posedge clk);
        chk("hitless pulses", 8'h01, 8'(hs_cnt));
        chk("hitless drops", 8'h00, 8'(drop_cnt));
        $display("Test hitless done");

        // Loss of every input ends in holdover or freerun
        @(posedge clk) loss_req <= 4'hf;
        wait_for("all lost", 2'h0, ST_HOLD, 1'b0);
        @(posedge clk) history_valid <= 1'b0;
        @(posedge clk) loss_req <= 4'h0;
        wait_for("recovered", 2'h1, ST_TRACK, 1'b0);
        @(posedge clk) loss_req <= 4'hf;
        wait_for("lost no history", 2'h0, ST_FREE, 1'b0);
        @(posedge clk) loss_req <= 4'h0;
        wait_for("lost cleared", 2'h2, ST_TRACK, 1'b0);
        $display("Test fault entry done");

        // Forced holdover follows history, clearing resumes tracking
        wr(`ADDR_FORCE_HOLD, 8'h01);
        wait_for("forced free", 2'h0, ST_FREE, 1'b0);
        @(posedge clk) history_valid <= 1'b1;
        wait_for("forced hold", 2'h0, ST_HOLD, 1'b0);
        wr(`ADDR_FORCE_HOLD, 8'h00);
        wait_for("force cleared", 2'h2, ST_TRACK, 1'b1);
        rd("select status", `ADDR_SEL_STATUS, 8'h06);
        $display("Test force holdover done");

        // Clock enable low freezes selection, synchronisers and outputs
        @(posedge clk) clk_en <= 1'b0;
        loss_req <= 4'h4;
        repeat (12) @(posedge clk);
        #1;
        chk("frozen sel", 8'h02, {6'h0, sel_input});
        chk("frozen state", {5'h0, ST_TRACK}, {5'h0, state_now});
        @(posedge clk) clk_en <= 1'b1;
        wait_for("unfrozen", 2'h3, ST_TRACK, 1'b1);
        $display("Test clock enable done");

        stop_test();
    end
endmodule : testbench
`default_nettype wire
